// ==== hw/crosspoint_pkg.sv ====
package crosspoint_pkg;

  // switch geometry
  localparam int NUM_OUTPUTS = 16;
  localparam int FIELD_W = 6;
  localparam int CHAIN_W = 96;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int OUT_IDX_W = 4;

  // field layout, shared by chain fields and the single-output word
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 4;
  localparam int GAIN_BIT = 4;
  localparam int EN_BIT = 5;
  localparam int OUT_IDX_LSB = 6;
  localparam int CHIP_ADDR_LSB = 10;

  // apb register byte offsets
  localparam logic [11:0] STATUS_OFS = 12'h0000;
  localparam logic [11:0] MASK_OFS = 12'h0004;
  localparam logic [11:0] CFG0_OFS = 12'h0008;
  localparam logic [11:0] CFG1_OFS = 12'h000C;
  localparam logic [11:0] CFG2_OFS = 12'h0010;
  localparam logic [11:0] WORD_OFS = 12'h0014;

  // status register bit positions
  localparam int ST_MODE_BIT = 0;
  localparam int ST_MATCH_BIT = 1;
  localparam int ST_STRAP_LSB = 2;
  localparam int ST_UPD_BIT = 6;
  localparam int ST_CE_BIT = 7;

  // reset values
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic en;
    logic gain;
    logic [3:0] sel;
  } out_cfg_type;

  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_COMMIT = 2'b01,
    UPD_HOLD = 2'b10
  } upd_state_type;

endpackage

// ==== hw/crosspoint_serial_control.sv ====
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - sample serial input on falling shift clock
// - full-chain mode shifts through 96-bit register
// - single-output mode passes input straight to output
// - drive address-match flag low on own address
// - enable high: ignore shift clock and input
// - mode pin high full-chain, low single-output
// - reset immediately disables outputs, restores defaults
// - update low commits shifted data to latches
// - chip address from four static straps
// - per-output gain, unity or double
// - per-output enable, disabled output high-impedance
// - power-up disables every output like reset
// - match word bits 13..10 before decoding
// - word bit 4 gain, bit 5 enable
// - word bits 3..0 select input channel
// - chain output delayed exactly 96 shift clocks
module crosspoint_serial_control
  import crosspoint_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link, clocked by the host
  input wire logic sclk,
  input wire logic ce_n,
  input wire logic din,
  output logic dout,
  input wire logic mode,
  input wire logic update_n,
  // device reset pin and address straps
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] chip_addr_straps,
  output logic addr_match_n,
  // switch control to the analog matrix
  output out_cfg_type [NUM_OUTPUTS-1:0] video_outputs
);

  // ---------------------------------------------------------------
  // link domain: shift registers on the falling shift clock edge
  // ---------------------------------------------------------------
  // chain bits 6g+5..6g drive output g; output 15 is shifted in first
  logic [CHAIN_W-1:0] chain_reg;
  logic [WORD_W-1:0] word_reg;

  // presetn stands in for power-up only; the reset pin does not touch
  // these, so a reset between shift and update loses nothing
  always_ff @(negedge sclk or negedge presetn) begin
    if (!presetn) begin
      chain_reg <= '0;
    end else if (!ce_n && mode) begin
      chain_reg <= {chain_reg[CHAIN_W-2:0], din};
    end
  end

  always_ff @(negedge sclk or negedge presetn) begin
    if (!presetn) begin
      word_reg <= '0;
    end else if (!ce_n && !mode) begin
      word_reg <= {word_reg[WORD_W-2:0], din};
    end
  end

  // single-output mode: every chained device sees the same word
  always_comb begin
    if (mode) begin
      dout = chain_reg[CHAIN_W-1];
    end else begin
      dout = din;
    end
  end

  // ---------------------------------------------------------------
  // bus domain: pin synchronisers
  // ---------------------------------------------------------------
  logic upd_meta_reg;
  logic upd_sync_reg;
  logic mode_meta_reg;
  logic mode_sync_reg;
  logic ce_meta_reg;
  logic ce_sync_reg;
  logic [ADDR_W-1:0] strap_meta_reg;
  logic [ADDR_W-1:0] strap_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_meta_reg <= 1'b1;
      upd_sync_reg <= 1'b1;
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
      ce_meta_reg <= 1'b1;
      ce_sync_reg <= 1'b1;
    end else begin
      upd_meta_reg <= update_n;
      upd_sync_reg <= upd_meta_reg;
      mode_meta_reg <= mode;
      mode_sync_reg <= mode_meta_reg;
      ce_meta_reg <= ce_n;
      ce_sync_reg <= ce_meta_reg;
    end
  end

  // straps are static; caught continuously after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      strap_meta_reg <= chip_addr_straps;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // update sequencing
  // ---------------------------------------------------------------
  // the shift registers are read only once update is seen low; the
  // host may not pulse the shift clock while update is low, so the
  // words are stable across the crossing
  logic arst_n;
  upd_state_type upd_state_reg;
  upd_state_type upd_state_next;
  logic commit;
  logic commit_full;
  logic commit_single;
  logic addr_hit;
  logic [OUT_IDX_W-1:0] word_out_idx;

  assign arst_n = presetn & reset_n;

  // either reset clears the latches at once; release is retimed through
  // two flip-flops so no latch leaves reset on an edge that the reset
  // pin happened to cross, which would split the outputs across cycles
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic latch_rst_n;

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign latch_rst_n = rst_sync_reg;

  assign addr_hit = (word_reg[CHIP_ADDR_LSB +: ADDR_W]
                     == strap_sync_reg);
  assign word_out_idx = word_reg[OUT_IDX_LSB +: OUT_IDX_W];

  // one commit per update pulse: hold waits for update to rise again
  always_comb begin
    upd_state_next = upd_state_reg;
    unique case (upd_state_reg)
      UPD_IDLE: begin
        if (!upd_sync_reg && !ce_sync_reg) begin
          upd_state_next = UPD_COMMIT;
        end
      end
      UPD_COMMIT: begin
        upd_state_next = UPD_HOLD;
      end
      UPD_HOLD: begin
        if (upd_sync_reg) begin
          upd_state_next = UPD_IDLE;
        end
      end
      default: begin
        upd_state_next = UPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge latch_rst_n) begin
    if (!latch_rst_n) begin
      upd_state_reg <= UPD_IDLE;
    end else begin
      upd_state_reg <= upd_state_next;
    end
  end

  assign commit = (upd_state_reg == UPD_COMMIT);
  // mode is taken from its synchronised copy at the commit itself
  assign commit_full = commit && mode_sync_reg;
  assign commit_single = commit && !mode_sync_reg && addr_hit;

  // flag stays low for as long as update is held after a match
  always_ff @(posedge pclk or negedge latch_rst_n) begin
    if (!latch_rst_n) begin
      addr_match_n <= 1'b1;
    end else if (commit_single) begin
      addr_match_n <= 1'b0;
    end else if (upd_state_reg == UPD_IDLE) begin
      addr_match_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // switch latches and output stage, one per output
  // ---------------------------------------------------------------
  logic [NUM_OUTPUTS-1:0] mask_reg;
  out_cfg_type [NUM_OUTPUTS-1:0] latch_reg;
  out_cfg_type [NUM_OUTPUTS-1:0] out_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : gen_out
      always_ff @(posedge pclk or negedge latch_rst_n) begin
        if (!latch_rst_n) begin
          latch_reg[g] <= '0;
        end else if (commit_full) begin
          latch_reg[g].sel <=
            chain_reg[g*FIELD_W+SEL_LSB +: SEL_W];
          latch_reg[g].gain <= chain_reg[g*FIELD_W+GAIN_BIT];
          latch_reg[g].en <= chain_reg[g*FIELD_W+EN_BIT];
        end else if (commit_single
                     && word_out_idx == OUT_IDX_W'(g)) begin
          latch_reg[g].sel <= word_reg[SEL_LSB +: SEL_W];
          latch_reg[g].gain <= word_reg[GAIN_BIT];
          latch_reg[g].en <= word_reg[EN_BIT];
        end
      end

      // software mask can hold an output off regardless of the latch
      always_ff @(posedge pclk or negedge latch_rst_n) begin
        if (!latch_rst_n) begin
          out_reg[g] <= '0;
        end else begin
          out_reg[g].sel <= latch_reg[g].sel;
          out_reg[g].gain <= latch_reg[g].gain;
          out_reg[g].en <= latch_reg[g].en & ~mask_reg[g];
        end
      end

      assign video_outputs[g] = out_reg[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // apb slave: zero wait states, read data prepared in setup
  // ---------------------------------------------------------------
  logic [CHAIN_W-1:0] latch_flat;
  logic addr_ok;
  logic wr_access;
  logic [31:0] status_word;
  logic [31:0] rdata_next;

  assign latch_flat = latch_reg;
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      STATUS_OFS, MASK_OFS, CFG0_OFS, CFG1_OFS, CFG2_OFS, WORD_OFS: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // writes to read-only offsets are dropped quietly, with no error
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_access = psel & penable & pwrite & addr_ok;

  // status shows the synchronised pin copies, never a raw pin, so a
  // read cannot catch a pin in the middle of a transition
  always_comb begin
    status_word = '0;
    status_word[ST_MODE_BIT] = mode_sync_reg;
    status_word[ST_MATCH_BIT] = ~addr_match_n;
    status_word[ST_STRAP_LSB +: ADDR_W] = strap_sync_reg;
    status_word[ST_UPD_BIT] = ~upd_sync_reg;
    status_word[ST_CE_BIT] = ~ce_sync_reg;
  end

  always_comb begin
    rdata_next = RDATA_RESET;
    unique case (paddr)
      STATUS_OFS: begin
        rdata_next = status_word;
      end
      MASK_OFS: begin
        rdata_next = {16'h0000, mask_reg};
      end
      CFG0_OFS: begin
        rdata_next = latch_flat[31:0];
      end
      CFG1_OFS: begin
        rdata_next = latch_flat[63:32];
      end
      CFG2_OFS: begin
        rdata_next = latch_flat[95:64];
      end
      // raw link-domain word: only consistent while no frame runs,
      // software must read it between frames
      WORD_OFS: begin
        rdata_next = {16'h0000, word_reg};
      end
      default: begin
        rdata_next = RDATA_RESET;
      end
    endcase
  end

  // read data is caught in setup, so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_RESET;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  // mask survives the device reset pin; only bus reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= MASK_RESET;
    end else if (wr_access && paddr == MASK_OFS) begin
      if (pstrb[0]) begin
        mask_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        mask_reg[15:8] <= pwdata[15:8];
      end
    end
  end

endmodule

// ==== tb/crosspoint_checker.sv ====
`timescale 1ns/1ps
module crosspoint_checker
  import crosspoint_pkg::*;
(
  // bus side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // link and device pins
  input wire logic din,
  input wire logic dout,
  input wire logic ce_n,
  input wire logic mode,
  input wire logic update_n,
  input wire logic reset_n,
  input wire logic addr_match_n,
  input wire out_cfg_type [NUM_OUTPUTS-1:0] video_outputs
);
  logic [3:0] upd_cnt;
  logic [1:0] wr_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // outputs may only move a few cycles after update low or any bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) upd_cnt <= 4'hf;
    else if (!update_n) upd_cnt <= 4'h0;
    else if (upd_cnt != 4'hf) upd_cnt <= upd_cnt + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_cnt <= 2'h3;
    else if (psel && penable && pwrite) wr_cnt <= 2'h0;
    else if (wr_cnt != 2'h3) wr_cnt <= wr_cnt + 2'h1;
  end
  chk_commit_only: assert property (
    $changed(video_outputs) && reset_n && $past(reset_n)
    |-> upd_cnt < 4'h8 || wr_cnt < 2'h3) else $error("stray change");
  chk_chain_idle: assert property (
    mode && $past(mode) && ce_n && $past(ce_n) |-> $stable(dout))
    else $error("dout moved while idle");
  chk_pass_thru: assert property (
    !mode |-> dout == din) else $error("dout not din");
  chk_reset_clears: assert property (
    !reset_n |-> video_outputs == '0) else $error("outputs live");
  chk_reset_flag: assert property (
    !reset_n |-> addr_match_n) else $error("flag low in reset");
  chk_powerup_off: assert property (
    $rose(presetn) |-> video_outputs == '0) else $error("powerup live");
  chk_match_cause: assert property (
    $fell(addr_match_n) |-> !update_n && !mode) else $error("bad match");
  chk_match_release: assert property (
    update_n [*7] |-> addr_match_n) else $error("flag stuck low");
endmodule
bind crosspoint_serial_control crosspoint_checker u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .din, .dout, .ce_n, .mode, .update_n,
  .reset_n, .addr_match_n, .video_outputs);

// ==== tb/crosspoint_serial_control_tb.sv ====
`timescale 1ns/1ps
module crosspoint_serial_control_tb;
  import crosspoint_pkg::*;
  localparam logic [95:0] P1 = 96'h1234_5678_9abc_def0_0f1e_2d3c;
  localparam logic [95:0] P2 = 96'ha5a5_5a5a_c3c3_3c3c_f00f_0ff0;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic sclk, ce_n, din, dout, mode, update_n, reset_n, amn;
  logic [11:0] paddr;
  logic [3:0] pstrb, straps;
  logic [31:0] pwdata, prdata, rd;
  logic [95:0] e;
  out_cfg_type [NUM_OUTPUTS-1:0] vo;
  int n_errors = 0;
  int cmp_count = 0;
  crosspoint_serial_control dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .sclk, .ce_n, .din, .dout, .mode, .update_n, .reset_n,
    .chip_addr_straps(straps), .addr_match_n(amn), .video_outputs(vo));
  serial_host host (.sclk, .din, .ce_n, .mode, .update_n, .dout,
    .addr_match_n(amn));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task chk(string s, logic [95:0] seen, logic [95:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task t_regs;
    apb(1'b0, STATUS_OFS, '0);
    chk("status", rd, 32'h0000_0029);
    apb(1'b0, 12'h018, '0);
    chk("slverr", er, 1'b1);
    chk("bad rdata", rd, '0);
    $display("regs done");
  endtask
  task t_chain;
    host.send(P1, 96, 1'b1, 1'b1);
    host.commit(1'b1);
    chk("out p1", vo, P1);
    host.send(P2, 96, 1'b1, 1'b1);
    chk("dout", host.seen, P1);
    host.commit(1'b1);
    chk("out p2", vo, P2);
    apb(1'b0, CFG0_OFS, '0);
    chk("latch0", rd, P2[31:0]);
    apb(1'b0, CFG2_OFS, '0);
    chk("latch2", rd, P2[95:64]);
    apb(1'b1, MASK_OFS, 32'h0000_ffff);
    repeat (2) @(posedge pclk);
    chk("masked", vo, P2 & ~{16{6'h20}});
    apb(1'b1, MASK_OFS, '0);
    pstrb <= 4'h1;
    apb(1'b1, MASK_OFS, 32'h0000_ffff);
    pstrb <= 4'hf;
    apb(1'b0, MASK_OFS, '0);
    chk("lane mask", rd, 32'h0000_00ff);
    chk("half masked", vo, P2 & ~{{8{6'h00}}, {8{6'h20}}});
    apb(1'b1, MASK_OFS, '0);
    repeat (2) @(posedge pclk);
    chk("unmasked", vo, P2);
    $display("chain done");
  endtask
  task t_single;
    e = P2;
    e[23:18] = 6'h39;
    host.send({80'h0, 16'h28f9}, 16, 1'b0, 1'b1);
    host.commit(1'b0);
    chk("match", host.hit, 1'b1);
    chk("single", vo, e);
    host.send({80'h0, 16'h15f9}, 16, 1'b0, 1'b1);
    host.commit(1'b0);
    chk("no match", host.hit, 1'b0);
    chk("kept", vo, e);
    apb(1'b0, WORD_OFS, '0);
    chk("word", rd, 32'h0000_15f9);
    $display("single done");
  endtask
  task t_ce_reset;
    host.send(P1, 96, 1'b1, 1'b0);
    host.commit(1'b1);
    chk("ce off", vo, P2);
    @(posedge pclk);
    reset_n <= 1'b0;
    #1;
    chk("reset out", vo, '0);
    chk("reset flag", amn, 1'b1);
    @(posedge pclk);
    reset_n <= 1'b1;
    host.commit(1'b1);
    chk("chain kept", vo, P2);
    $display("ce and reset done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    straps = 4'ha;
    reset_n = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("powerup", vo, '0);
    t_regs;
    t_chain;
    t_single;
    t_ce_reset;
    close_out;
  end
  initial begin
    #500000;
    n_errors++;
    close_out;
  end
endmodule

// ==== tb/serial_host.sv ====
`timescale 1ns/1ps
module serial_host (
  // link to the device
  output logic sclk,
  output logic din,
  output logic ce_n,
  output logic mode,
  output logic update_n,
  input wire logic dout,
  input wire logic addr_match_n
);
  logic [95:0] seen;
  logic hit;
  initial begin
    sclk = 1'b1;
    din = 1'b0;
    ce_n = 1'b1;
    mode = 1'b1;
    update_n = 1'b1;
  end
  // shift clock idles high and only runs inside a frame, msb first
  task send(input logic [95:0] v, input int n, input logic m,
            input logic en);
    mode = m;
    ce_n = !en;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      din = v[i];
      #62.5;
      seen = {seen[94:0], dout};
      sclk = 1'b0;
      #62.5;
      sclk = 1'b1;
    end
    #100;
    din = !din;
    ce_n = 1'b1;
  endtask
  // update held low for 480 ns, well past the 100 ns minimum
  task commit(input logic m);
    mode = m;
    ce_n = 1'b0;
    hit = 1'b0;
    #100;
    update_n = 1'b0;
    repeat (12) begin
      #40;
      hit = hit | !addr_match_n;
    end
    update_n = 1'b1;
    #200;
    ce_n = 1'b1;
  endtask
endmodule
